/* rtl/vcsp_top.sv */
// Operation
// - config bit 0 low means shutdown
// - lock blocks shift-limit, grids, output-map writes
// - output map pointer writable while locked
// - bit 2 picks slow or fast blink
// - bit 3 picks 14 or 16 segment font
// - resync bit clears blink counters at frame end
// - resync also restarts display multiplexing
// - clear bit wipes segment data 0x20-0x7F
// - bit 6 picks one or two digits/grid
// - config read bit 7 shows blink phase
// - din sampled on sclk rise, select low
// - sclk and din ignored while select high
// - serial out routed to pump or ports
// - serial out always driven, never floating
// - din reaches serial out 15.5 clocks later
// - aux output zero low after reset
// - select rise latches and executes shift word
// - last sixteen bits kept across frames
// - read answer shifted out next frame
`timescale 1ns/1ps

module vcsp_top
  import vcsp_pkg::*;
#(
  parameter int unsigned SLOW_HALF_CYC = BLINK_SLOW_HALF_CYC,
  parameter int unsigned FAST_HALF_CYC = BLINK_FAST_HALF_CYC
)
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_din,
  output logic cfg_normal_run,
  output logic cfg_lock,
  output logic cfg_blink_fast,
  output logic cfg_font_16seg,
  output logic cfg_two_per_grid,
  output logic blink_state_second,
  output logic mux_restart,
  output logic data_clear,
  output logic [7:0] grids_value,
  output logic [7:0] shift_limit_value,
  output logic aux_output_zero,
  output logic aux_output_one,
  output logic pump_output
);

  localparam logic [BLINK_CNT_W-1:0] SLOW_LIMIT = BLINK_CNT_W'(SLOW_HALF_CYC - 1);
  localparam logic [BLINK_CNT_W-1:0] FAST_LIMIT = BLINK_CNT_W'(FAST_HALF_CYC - 1);

  // ----------------------------------------------------------------
  // link domain: shift register on sclk
  // ----------------------------------------------------------------
  logic [FRAME_W-1:0] link_sr_reg;
  logic [FRAME_W-1:0] link_sr_next;
  logic link_seen_reg;
  logic link_seen_next;
  logic link_dout_reg;
  logic [FRAME_W-1:0] resp_word_reg;
  logic [FRAME_W-1:0] resp_word_next;
  logic resp_tog_reg;
  logic resp_tog_next;

  // resp_word/resp_tog only change while select is high, so they are
  // quasi-static by the time the next frame starts clocking
  always_comb
  begin
    link_sr_next = link_sr_reg;
    link_seen_next = link_seen_reg;
    if (!spi_cs_n)
    begin
      link_seen_next = resp_tog_reg;
      if (resp_tog_reg != link_seen_reg)
      begin
        // first bit of the answer (read flag) is skipped: it may read either way
        link_sr_next = {resp_word_reg[FRAME_W-2:0], spi_din};
      end
      else
      begin
        link_sr_next = {link_sr_reg[FRAME_W-2:0], spi_din};
      end
    end
  end

  // no reset here: the link clock may stand still during sys_rst
  always_ff @(posedge spi_sclk)
  begin
    link_sr_reg <= link_sr_next;
    link_seen_reg <= link_seen_next;
  end

  // falling edge launch gives the half cycle and keeps data stable at rise
  always_ff @(negedge spi_sclk)
  begin
    link_dout_reg <= link_sr_reg[FRAME_W-1];
  end

  // ----------------------------------------------------------------
  // select synchroniser
  // ----------------------------------------------------------------
  logic [CS_SYNC_LEN-1:0] cs_sync_reg;
  logic [CS_SYNC_LEN-1:0] cs_sync_next;
  logic cs_level_reg;
  logic cs_level_next;
  logic frame_end;

  always_comb
  begin
    cs_sync_next = {cs_sync_reg[CS_SYNC_LEN-2:0], spi_cs_n};
    cs_level_next = cs_level_reg;
    if (cs_sync_reg[1] == cs_sync_reg[2])
    begin
      cs_level_next = cs_sync_reg[2];
    end
    frame_end = (cs_sync_reg[1] == cs_sync_reg[2]) && cs_sync_reg[2] && !cs_level_reg;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      cs_sync_reg <= '1;
      cs_level_reg <= 1'b1;
    end
    else
    begin
      cs_sync_reg <= cs_sync_next;
      cs_level_reg <= cs_level_next;
    end
  end

  // ----------------------------------------------------------------
  // command execution
  // ----------------------------------------------------------------
  logic [7:0] cfg_reg;
  logic [7:0] cfg_next;
  logic [7:0] grids_reg;
  logic [7:0] grids_next;
  logic [7:0] shift_limit_reg;
  logic [7:0] shift_limit_next;
  logic [7:0] port_cfg_reg;
  logic [7:0] port_cfg_next;
  logic [OUTMAP_PTR_W-1:0] outmap_ptr_reg;
  logic [OUTMAP_PTR_W-1:0] outmap_ptr_next;
  logic [7:0] outmap_reg [OUTMAP_DEPTH];
  logic [7:0] outmap_next [OUTMAP_DEPTH];
  logic resync_pulse_reg;
  logic resync_pulse_next;
  logic clear_pulse_reg;
  logic clear_pulse_next;
  logic blink_phase_reg;
  logic [FRAME_W-1:0] word;
  logic [ADDR_W-1:0] cmd_addr;
  logic [DATA_W-1:0] cmd_data;

  function automatic logic is_locked_addr(input logic [ADDR_W-1:0] a);
    is_locked_addr = (a == ADDR_SHIFT_LIMIT) || (a == ADDR_GRIDS) || (a == ADDR_OUTMAP_DATA);
  endfunction : is_locked_addr

  function automatic logic [7:0] read_value(input logic [ADDR_W-1:0] a);
    case (a)
      ADDR_CONFIG: read_value = {blink_phase_reg, cfg_reg[6:0] & CFG_STORED_MASK[6:0]};
      ADDR_GRIDS: read_value = grids_reg;
      ADDR_SHIFT_LIMIT: read_value = shift_limit_reg;
      ADDR_OUTMAP_PTR: read_value = {4'h0, outmap_ptr_reg};
      ADDR_OUTMAP_DATA: read_value = outmap_reg[outmap_ptr_reg];
      ADDR_PORT_CFG: read_value = port_cfg_reg;
      default: read_value = 8'h00;
    endcase
  endfunction : read_value

  always_comb
  begin
    word = link_sr_reg;
    cmd_addr = word[FRAME_RW_BIT-1:FRAME_ADDR_LSB];
    cmd_data = word[DATA_W-1:0];
    cfg_next = cfg_reg;
    grids_next = grids_reg;
    shift_limit_next = shift_limit_reg;
    port_cfg_next = port_cfg_reg;
    outmap_ptr_next = outmap_ptr_reg;
    outmap_next = outmap_reg;
    resp_word_next = resp_word_reg;
    resp_tog_next = resp_tog_reg;
    resync_pulse_next = 1'b0;
    clear_pulse_next = 1'b0;
    if (frame_end)
    begin
      if (word[FRAME_RW_BIT])
      begin
        resp_word_next = {word[FRAME_W-1:FRAME_ADDR_LSB], read_value(cmd_addr)};
        resp_tog_next = ~resp_tog_reg;
      end
      else if (cfg_reg[CFG_LOCK_BIT] && is_locked_addr(cmd_addr))
      begin
        // dropped silently: nothing at all changes
        cfg_next = cfg_reg;
      end
      else
      begin
        case (cmd_addr)
          ADDR_CONFIG:
          begin
            cfg_next = cmd_data & CFG_STORED_MASK;
            resync_pulse_next = cmd_data[CFG_RESYNC_BIT];
            clear_pulse_next = cmd_data[CFG_CLEAR_BIT];
          end
          ADDR_GRIDS: grids_next = cmd_data;
          ADDR_SHIFT_LIMIT: shift_limit_next = cmd_data;
          ADDR_OUTMAP_PTR: outmap_ptr_next = cmd_data[OUTMAP_PTR_W-1:0];
          ADDR_OUTMAP_DATA: outmap_next[outmap_ptr_reg] = cmd_data;
          ADDR_PORT_CFG: port_cfg_next = cmd_data;
          default: cfg_next = cfg_reg; // no-op and unknown addresses
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      cfg_reg <= CFG_RESET;
      grids_reg <= GRIDS_RESET;
      shift_limit_reg <= SHIFT_LIMIT_RESET;
      port_cfg_reg <= PORT_CFG_RESET;
      outmap_ptr_reg <= '0;
      resp_word_reg <= '0;
      resp_tog_reg <= 1'b0;
      resync_pulse_reg <= 1'b0;
      clear_pulse_reg <= 1'b0;
    end
    else
    begin
      cfg_reg <= cfg_next;
      grids_reg <= grids_next;
      shift_limit_reg <= shift_limit_next;
      port_cfg_reg <= port_cfg_next;
      outmap_ptr_reg <= outmap_ptr_next;
      resp_word_reg <= resp_word_next;
      resp_tog_reg <= resp_tog_next;
      resync_pulse_reg <= resync_pulse_next;
      clear_pulse_reg <= clear_pulse_next;
    end
  end

  generate
    for (genvar i = 0; i < OUTMAP_DEPTH; i++)
    begin : g_outmap
      always_ff @(posedge sys_clk)
      begin
        if (sys_rst)
        begin
          outmap_reg[i] <= OUTMAP_RESET;
        end
        else
        begin
          outmap_reg[i] <= outmap_next[i];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // blink timing
  // ----------------------------------------------------------------
  // sys_clk stands in for the multiplex clock, so periods scale with it
  logic [BLINK_CNT_W-1:0] blink_cnt_reg;
  logic [BLINK_CNT_W-1:0] blink_cnt_next;
  logic blink_phase_next;
  logic [BLINK_CNT_W-1:0] blink_limit;

  always_comb
  begin
    blink_limit = cfg_reg[CFG_BLINK_FAST_BIT] ? FAST_LIMIT : SLOW_LIMIT;
    blink_cnt_next = blink_cnt_reg + 1'b1;
    blink_phase_next = blink_phase_reg;
    if (resync_pulse_reg)
    begin
      blink_cnt_next = '0;
      blink_phase_next = 1'b0;
    end
    else if (blink_cnt_reg >= blink_limit)
    begin
      blink_cnt_next = '0;
      blink_phase_next = ~blink_phase_reg;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      blink_cnt_reg <= '0;
      blink_phase_reg <= 1'b0;
    end
    else
    begin
      blink_cnt_reg <= blink_cnt_next;
      blink_phase_reg <= blink_phase_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  function automatic logic port_level(input logic [1:0] mode, input logic serial_bit);
    case (mode)
      VCSP_PORT_HIGH: port_level = 1'b1;
      VCSP_PORT_SERIAL: port_level = serial_bit;
      default: port_level = 1'b0;
    endcase
  endfunction : port_level

  // ports are push-pull: the serial bit is driven even while deselected
  assign aux_output_zero = port_level(port_cfg_reg[PORT0_LSB +: 2], link_dout_reg);
  assign aux_output_one = port_level(port_cfg_reg[AUX_OUTPUT_ONE_LSB +: 2], link_dout_reg);
  assign pump_output = port_level(port_cfg_reg[PUMP_LSB +: 2], link_dout_reg);

  assign cfg_normal_run = cfg_reg[CFG_RUN_BIT];
  assign cfg_lock = cfg_reg[CFG_LOCK_BIT];
  assign cfg_blink_fast = cfg_reg[CFG_BLINK_FAST_BIT];
  assign cfg_font_16seg = cfg_reg[CFG_FONT16_BIT];
  assign cfg_two_per_grid = cfg_reg[CFG_MODE96_BIT];
  assign blink_state_second = blink_phase_reg;
  assign mux_restart = resync_pulse_reg;
  assign data_clear = clear_pulse_reg;
  assign grids_value = grids_reg;
  assign shift_limit_value = shift_limit_reg;

endmodule : vcsp_top

/* rtl/vcsp_pkg.sv */
package vcsp_pkg;

  // ----------------------------------------------------------------
  // clocking and blink timing
  // ----------------------------------------------------------------
  localparam int unsigned SYS_CLK_HZ = 20_000_000;
  localparam int unsigned BLINK_SLOW_HALF_MS = 1000;
  localparam int unsigned BLINK_FAST_HALF_MS = 500;
  localparam int unsigned BLINK_SLOW_HALF_CYC = (SYS_CLK_HZ / 1000) * BLINK_SLOW_HALF_MS;
  localparam int unsigned BLINK_FAST_HALF_CYC = (SYS_CLK_HZ / 1000) * BLINK_FAST_HALF_MS;
  localparam int BLINK_CNT_W = 25;

  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam int FRAME_W = 16;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int FRAME_RW_BIT = 15;
  localparam int FRAME_ADDR_LSB = 8;
  localparam int CS_SYNC_LEN = 3;

  // ----------------------------------------------------------------
  // command addresses
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_NOOP = 7'h00;
  localparam logic [6:0] ADDR_GRIDS = 7'h03;
  localparam logic [6:0] ADDR_CONFIG = 7'h04;
  localparam logic [6:0] ADDR_OUTMAP_DATA = 7'h06;
  localparam logic [6:0] ADDR_OUTMAP_PTR = 7'h07;
  localparam logic [6:0] ADDR_PORT_CFG = 7'h09;
  localparam logic [6:0] ADDR_SHIFT_LIMIT = 7'h0E;

  // ----------------------------------------------------------------
  // configuration fields
  // ----------------------------------------------------------------
  localparam int CFG_RUN_BIT = 0;
  localparam int CFG_LOCK_BIT = 1;
  localparam int CFG_BLINK_FAST_BIT = 2;
  localparam int CFG_FONT16_BIT = 3;
  localparam int CFG_RESYNC_BIT = 4;
  localparam int CFG_CLEAR_BIT = 5;
  localparam int CFG_MODE96_BIT = 6;
  localparam int CFG_PHASE_BIT = 7;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] CFG_STORED_MASK = 8'h4F;
  localparam logic [7:0] GRIDS_RESET = 8'h00;
  localparam logic [7:0] SHIFT_LIMIT_RESET = 8'h00;
  localparam logic [7:0] PORT_CFG_RESET = 8'h00;
  localparam logic [7:0] OUTMAP_RESET = 8'h00;

  // ----------------------------------------------------------------
  // output map storage and port routing
  // ----------------------------------------------------------------
  localparam int OUTMAP_DEPTH = 16;
  localparam int OUTMAP_PTR_W = 4;
  localparam int PORT0_LSB = 0;
  localparam int AUX_OUTPUT_ONE_LSB = 2;
  localparam int PUMP_LSB = 4;

  typedef enum logic [1:0] {
    VCSP_PORT_LOW = 2'b00,
    VCSP_PORT_HIGH = 2'b01,
    VCSP_PORT_SERIAL = 2'b10
  } vcsp_port_mode_t;

endpackage : vcsp_pkg

/* verification/vcsp_master.sv */
`timescale 1ns/1ps
module vcsp_master (
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic dout
);
  // ------------------------------------------------
  // link master, sclk stands low between frames
  // ------------------------------------------------
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b1;
  end

  task automatic xfer(input logic [31:0] word, input int n, output logic [31:0] got);
    got = 32'h0;
    cs_n = 1'b0;
    #24;
    for (int i = n - 1; i >= 0; i--)
    begin
      din = word[i];
      #24 sclk = 1'b1;
      got = {got[30:0], dout};
      #24;
      if (i != 0) sclk = 1'b0;
    end
    // select rises while sclk is still high
    cs_n = 1'b1;
    #12 sclk = 1'b0;
    din = ~din;
    #600;
  endtask : xfer

  // clocking with select high, only when a test asks for it
  task automatic noise();
    for (int i = 0; i < 16; i++)
    begin
      din = ~din;
      #24 sclk = 1'b1;
      #24 sclk = 1'b0;
    end
    #100;
  endtask : noise
endmodule : vcsp_master

/* verification/vcsp_top_asserts.sv */
`timescale 1ns/1ps
module vcsp_top_asserts
  import vcsp_pkg::*;
#(
  parameter int unsigned SLOW_HALF_CYC = BLINK_SLOW_HALF_CYC,
  parameter int unsigned FAST_HALF_CYC = BLINK_FAST_HALF_CYC
)
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic spi_cs_n,
  input wire logic cfg_normal_run,
  input wire logic cfg_lock,
  input wire logic blink_state_second,
  input wire logic mux_restart,
  input wire logic data_clear,
  input wire logic [7:0] grids_value,
  input wire logic [7:0] shift_limit_value,
  input wire logic aux_output_zero,
  input wire logic aux_output_one,
  input wire logic pump_output
);
  // ------------------------------------------------
  // cycles since the last phase change or mux restart
  // ------------------------------------------------
  logic [31:0] cnt_reg, cnt_next;
  logic phase_reg, phase_next;
  always_comb
  begin
    phase_next = blink_state_second;
    cnt_next = cnt_reg + 32'h1;
    if (sys_rst || mux_restart || (blink_state_second != phase_reg)) cnt_next = 32'h0;
  end
  always_ff @(posedge sys_clk)
  begin
    cnt_reg <= cnt_next;
    phase_reg <= phase_next;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  chk_restart_pulse: assert property (mux_restart |=> !mux_restart)
    else $error("restart pulse longer than one cycle");
  chk_clear_pulse: assert property (data_clear |=> !data_clear)
    else $error("clear pulse longer than one cycle");
  chk_restart_phase: assert property (mux_restart |=> !blink_state_second)
    else $error("blink phase not restarted");
  chk_exec_after_cs: assert property ((mux_restart || data_clear) |-> spi_cs_n && $past(spi_cs_n, 3))
    else $error("action without select rise");
  chk_lock_hold: assert property (cfg_lock |=> $stable(grids_value) && $stable(shift_limit_value))
    else $error("locked register changed");
  chk_idle_pins: assert property ($fell(sys_rst) |-> !aux_output_zero && !aux_output_one && !pump_output)
    else $error("output pin not low after reset");
  chk_frame_quiet: assert property ((!spi_cs_n && !$past(spi_cs_n, 5))
    |-> $stable(cfg_lock) && $stable(cfg_normal_run) && $stable(grids_value))
    else $error("state changed inside a frame");
  chk_blink_period: assert property (cnt_reg <= SLOW_HALF_CYC + 4)
    else $error("blink phase stuck");
endmodule : vcsp_top_asserts

bind vcsp_top vcsp_top_asserts #(.SLOW_HALF_CYC(SLOW_HALF_CYC), .FAST_HALF_CYC(FAST_HALF_CYC)) vcsp_top_asserts_inst (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .spi_cs_n(spi_cs_n), .cfg_normal_run(cfg_normal_run),
  .cfg_lock(cfg_lock), .blink_state_second(blink_state_second), .mux_restart(mux_restart),
  .data_clear(data_clear), .grids_value(grids_value), .shift_limit_value(shift_limit_value),
  .aux_output_zero(aux_output_zero), .aux_output_one(aux_output_one), .pump_output(pump_output)
);

/* verification/tb.sv */
`timescale 1ns/1ps
module tb;
  import vcsp_pkg::*;
  localparam int unsigned SLOW = 400;
  localparam int unsigned FAST = 200;
  logic sys_clk, sys_rst, spi_sclk, spi_cs_n, spi_din;
  logic cfg_normal_run, cfg_lock, cfg_blink_fast, cfg_font_16seg, cfg_two_per_grid;
  logic blink_state_second, mux_restart, data_clear, aux_output_zero, aux_output_one, pump_output;
  logic [7:0] grids_value, shift_limit_value, rdata;
  logic [31:0] got;
  int n_fail, num_checks, cyc, n_clr, n_rs, t_rs;

  vcsp_top #(.SLOW_HALF_CYC(SLOW), .FAST_HALF_CYC(FAST)) vcsp_top_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_din(spi_din),
    .cfg_normal_run(cfg_normal_run), .cfg_lock(cfg_lock), .cfg_blink_fast(cfg_blink_fast),
    .cfg_font_16seg(cfg_font_16seg), .cfg_two_per_grid(cfg_two_per_grid),
    .blink_state_second(blink_state_second), .mux_restart(mux_restart), .data_clear(data_clear),
    .grids_value(grids_value), .shift_limit_value(shift_limit_value), .aux_output_zero(aux_output_zero),
    .aux_output_one(aux_output_one), .pump_output(pump_output));
  vcsp_master vcsp_master_inst (.sclk(spi_sclk), .cs_n(spi_cs_n), .din(spi_din), .dout(aux_output_zero));

  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    cyc++;
    if (data_clear === 1'b1) n_clr++;
    if (mux_restart === 1'b1) t_rs = cyc;
    if (mux_restart === 1'b1) n_rs++;
    if (cyc == 20000)
    begin
      n_fail++;
      close_out();
    end
  end

  // ------------------------------------------------
  // access and compare tasks
  // ------------------------------------------------
  task automatic close_out();
    if (n_fail == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  task automatic cmp_word(input logic [15:0] a, input logic [15:0] e);
    num_checks++;
    if (a !== e)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e);
    end
  endtask : cmp_word
  task automatic cmp_bit(input logic a, input logic e);
    cmp_word({15'h0, a}, {15'h0, e});
  endtask : cmp_bit
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    vcsp_master_inst.xfer({16'h0, 1'b0, a, d}, 16, got);
  endtask : wr
  // answer comes in the following frame, sent as a no-op
  task automatic rd(input logic [6:0] a, input bit noisy, output logic [7:0] d);
    vcsp_master_inst.xfer({16'h0, 1'b1, a, 8'h00}, 16, got);
    // both serial pins show the read flag, shifted in first and now in the top bit
    cmp_word({14'h0, pump_output, aux_output_zero}, 16'h0003);
    if (noisy) vcsp_master_inst.noise();
    vcsp_master_inst.xfer(32'h0, 16, got);
    d = got[7:0];
    cmp_word({9'h0, got[14:8]}, {9'h0, a});
  endtask : rd
  task automatic wait_until(input int t);
    while (cyc < t) @(negedge sys_clk);
  endtask : wait_until

  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial
  begin
    sys_rst = 1'b1;
    repeat (16) @(negedge sys_clk);
    sys_rst = 1'b0;
    cmp_bit(aux_output_zero, 1'b0);
    wr(ADDR_PORT_CFG, 8'h26);
    cmp_bit(aux_output_one, 1'b1);
    wr(ADDR_CONFIG, 8'h49);
    cmp_word({11'h0, cfg_two_per_grid, cfg_font_16seg, cfg_blink_fast, cfg_lock, cfg_normal_run}, 16'h0019);
    wr(ADDR_GRIDS, 8'h2F);
    wr(ADDR_SHIFT_LIMIT, 8'h12);
    wr(ADDR_CONFIG, 8'h03);
    wr(ADDR_GRIDS, 8'h05);
    wr(ADDR_SHIFT_LIMIT, 8'h77);
    wr(ADDR_OUTMAP_PTR, 8'h03);
    cmp_word({grids_value, shift_limit_value}, 16'h2F12);
    rd(ADDR_GRIDS, 1'b1, rdata);
    cmp_word({8'h0, rdata}, 16'h002F);
    rd(ADDR_OUTMAP_PTR, 1'b0, rdata);
    cmp_word({8'h0, rdata}, 16'h0003);
    wr(ADDR_CONFIG, 8'h01);
    wr(ADDR_GRIDS, 8'h05);
    cmp_word({8'h0, grids_value}, 16'h0005);
    // two words in one frame: only the trailing no-op executes
    vcsp_master_inst.xfer({1'b0, ADDR_GRIDS, 8'h33, 16'h0000}, 32, got);
    cmp_word({8'h0, grids_value}, 16'h0005);
    cmp_word(got[15:0], {1'b0, ADDR_GRIDS, 8'h33});
    wr(ADDR_CONFIG, 8'h21);
    wr(ADDR_CONFIG, 8'h01);
    cmp_word({n_clr[7:0], n_rs[7:0]}, 16'h0100);
    wr(ADDR_CONFIG, 8'h11);
    cmp_word({8'h0, n_rs[7:0]}, 16'h0001);
    rd(ADDR_CONFIG, 1'b0, rdata);
    cmp_word({8'h0, rdata}, 16'h0001);
    wait_until(t_rs + FAST + 10);
    cmp_bit(blink_state_second, 1'b0);
    wait_until(t_rs + SLOW + 10);
    cmp_bit(blink_state_second, 1'b1);
    wr(ADDR_CONFIG, 8'h15);
    cmp_bit(blink_state_second, 1'b0);
    wait_until(t_rs + FAST - 10);
    cmp_bit(blink_state_second, 1'b0);
    wait_until(t_rs + FAST + 10);
    cmp_bit(blink_state_second, 1'b1);
    rd(ADDR_CONFIG, 1'b0, rdata);
    cmp_word({8'h0, rdata}, 16'h0085);
    close_out();
  end
endmodule : tb
